// file: logic/mps_power_ctrl.sv
// Design decisions made here: the address map and strobed register access.
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// - wake input is active low
// - pin sleep: wake input high enters sleep
// - wake input low over 50ms exits sleep
// - idle sleep after serial idle timeout
// - attention command exits idle sleep
// - asleep: no answers, reports still flow
// - ring line wakes host on events
// - new message: ring line low 120ms
// - usb suspend sleeps, resume wakes
// - operating output high when LTE registered
// - network blink pattern per network state
// - data blink only after link success
// - function levels 0, 1, 4
// - level 0 rejects radio and SIM commands
// - level 4 rejects radio commands
// - level 1 restores full function
// - power key boots; key or battery shuts down
// - no sleep select or scripting build: sleep left on gpio, timer, message, data
// - software request sleeps outside the scripting build; no 30s auto sleep
// - scripting build sleeps whenever system idle
module mps_power_ctrl
  import mps_pkg::*;
#(
  parameter int TICK_CYCLES = mps_pkg::TICK_CYC
) (
  // clock and reset
  input  wire logic        clk_sys,
  input  wire logic        reset_n,
  // register port
  input  wire logic [3:0]  reg_addr,
  input  wire logic [15:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [15:0] reg_rdata,
  // pins from outside the clock domain
  input  wire logic        term_ready_n,
  input  wire logic        power_key,
  input  wire logic        batt_low,
  input  wire logic        usb_suspend,
  // serial side, same clock
  input  wire logic        serial_rx_act,
  input  wire logic        serial_tx_act,
  input  wire logic        cmd_valid,
  input  wire logic        cmd_attn,
  input  wire logic        cmd_radio,
  input  wire logic        cmd_sim,
  output logic             cmd_ack,
  output logic             cmd_nak,
  // system events, same clock
  input  wire logic        sms_evt,
  input  wire logic        data_evt,
  input  wire logic        call_ringing,
  input  wire logic        report_evt,
  input  wire logic        gpio_evt,
  input  wire logic        timer_evt,
  input  wire logic        alarm_evt,
  input  wire logic        sys_idle,
  // network state, same clock
  input  wire logic        lte_registered,
  input  wire logic        net_searching,
  input  wire logic        ppp_ok,
  input  wire logic        pdp_ok,
  input  wire logic        rndis_ok,
  // outputs
  output logic             ring_indicator,
  output logic             op_state,
  output logic             network_state_blink,
  output logic             power_on,
  output logic             asleep,
  output logic             radio_en,
  output logic             sim_en
);
  import mps_pkg::*;

  // ---------------------------------------------------------------
  // pin synchronisers and time base
  // ---------------------------------------------------------------
  logic [PIN_NUM-1:0] pin_raw;
  logic [PIN_NUM-1:0] sync1_r;
  logic [PIN_NUM-1:0] sync2_r;
  logic               pkey_d_r;
  logic [31:0]        div_r;
  logic               tick_r;

  assign pin_raw = {usb_suspend, batt_low, power_key, term_ready_n};

  // two flops per pin; the first one feeds nothing else
  genvar gi;
  generate
    for (gi = 0; gi < PIN_NUM; gi++) begin : g_sync
      always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
          sync1_r[gi] <= 1'b1;
          sync2_r[gi] <= 1'b1;
        end else begin
          sync1_r[gi] <= pin_raw[gi];
          sync2_r[gi] <= sync1_r[gi];
        end
      end
    end
  endgenerate

  logic dtr_hi, pkey_edge, batt_s, susp_s;
  assign dtr_hi    = sync2_r[PIN_DTR];
  assign pkey_edge = sync2_r[PIN_PKEY] & ~pkey_d_r;
  assign batt_s    = sync2_r[PIN_BATT];
  assign susp_s    = sync2_r[PIN_SUSP];

  // 1 ms enable pulse; all slow timing hangs off it
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      div_r    <= 32'h0000_0000;
      tick_r   <= 1'b0;
      pkey_d_r <= 1'b1;
    end else begin
      pkey_d_r <= sync2_r[PIN_PKEY];
      tick_r   <= (div_r == 32'(TICK_CYCLES - 1));
      div_r    <= (div_r == 32'(TICK_CYCLES - 1)) ? 32'h0000_0000 : div_r + 32'h1;
    end
  end

  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  logic [2:0]  fun_r;
  logic [1:0]  sel_r;
  logic        script_r;
  logic        sleep_req_r;
  logic [15:0] idle_lim_r;
  mps_pwr_t    pwr_r, pwr_nxt;

  function automatic logic hit(input logic [3:0] a, input logic [3:0] r);
    return a == r;
  endfunction : hit

  // function level writes only take legal levels
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      fun_r       <= FUN_RST;
      sel_r       <= SEL_RST;
      script_r    <= 1'b0;
      sleep_req_r <= 1'b0;
      idle_lim_r  <= IDLE_MS_RST;
    end else begin
      sleep_req_r <= 1'b0;
      if (reg_wr && hit(reg_addr, REG_CTRL)) begin
        if (reg_wdata[2:0] == FUN_MIN || reg_wdata[2:0] == FUN_FULL ||
            reg_wdata[2:0] == FUN_NORF) begin
          fun_r <= reg_wdata[2:0];
        end
        sel_r       <= reg_wdata[CTRL_SEL_LSB +: 2];
        script_r    <= reg_wdata[CTRL_SCRIPT];
        sleep_req_r <= reg_wdata[CTRL_SLEEP_REQ];
      end
      if (reg_wr && hit(reg_addr, REG_IDLE)) begin
        idle_lim_r <= reg_wdata;
      end
    end
  end

  // read data stands one cycle after the strobe; unmapped reads zero
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      reg_rdata <= 16'h0000;
    end else if (reg_rd) begin
      if (hit(reg_addr, REG_CTRL)) begin
        reg_rdata <= {10'h000, script_r, sel_r, fun_r};
      end else if (hit(reg_addr, REG_IDLE)) begin
        reg_rdata <= idle_lim_r;
      end else if (hit(reg_addr, REG_STATUS)) begin
        reg_rdata <= {12'h000, ~dtr_hi, pwr_r};
      end else begin
        reg_rdata <= 16'h0000;
      end
    end else begin
      reg_rdata <= 16'h0000;
    end
  end

  // ---------------------------------------------------------------
  // wake input low time and serial idle time
  // ---------------------------------------------------------------
  logic [15:0] dtr_cnt_r;
  logic [15:0] idle_cnt_r;
  logic        dtr_wake, idle_due;

  // low level is the wake request; any high restarts the count
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      dtr_cnt_r <= 16'h0000;
    end else if (dtr_hi) begin
      dtr_cnt_r <= 16'h0000;
    end else if (tick_r && dtr_cnt_r != 16'hFFFF) begin
      dtr_cnt_r <= dtr_cnt_r + 16'h1;
    end
  end
  assign dtr_wake = dtr_cnt_r > DTR_WAKE_MS;

  // any character either way restarts the idle wait
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      idle_cnt_r <= 16'h0000;
    end else if (serial_rx_act || serial_tx_act) begin
      idle_cnt_r <= 16'h0000;
    end else if (tick_r && idle_cnt_r != 16'hFFFF) begin
      idle_cnt_r <= idle_cnt_r + 16'h1;
    end
  end
  assign idle_due = idle_cnt_r > idle_lim_r;

  // ---------------------------------------------------------------
  // power state machine
  // ---------------------------------------------------------------
  logic wake_evt;
  assign wake_evt = gpio_evt | timer_evt | sms_evt | data_evt |
                    (script_r & alarm_evt);

  // shutdown sources beat every sleep or wake cause
  always_comb begin
    pwr_nxt = pwr_r;
    case (pwr_r)
      MPS_OFF: begin
        if (pkey_edge && !batt_s) pwr_nxt = MPS_ON;
      end
      MPS_ON: begin
        if (pkey_edge || batt_s) begin
          pwr_nxt = MPS_OFF;
        end else if (script_r) begin
          if (sys_idle) pwr_nxt = MPS_SLP;
        end else if (sleep_req_r) begin
          pwr_nxt = MPS_SLP;
        end else begin
          case (sel_r)
            SEL_PIN:  if (dtr_hi) pwr_nxt = MPS_SLP;
            SEL_IDLE: if (idle_due) pwr_nxt = MPS_SLP;
            SEL_USB:  if (susp_s) pwr_nxt = MPS_SLP;
            default:  pwr_nxt = MPS_ON;
          endcase
        end
      end
      MPS_SLP: begin
        if (pkey_edge || batt_s) begin
          pwr_nxt = MPS_OFF;
        end else if (script_r || sel_r == SEL_NONE) begin
          if (wake_evt) pwr_nxt = MPS_ON;
        end else begin
          case (sel_r)
            SEL_PIN:  if (dtr_wake) pwr_nxt = MPS_ON;
            SEL_IDLE: if (cmd_valid && cmd_attn) pwr_nxt = MPS_ON;
            SEL_USB:  if (!susp_s) pwr_nxt = MPS_ON;
            default:  pwr_nxt = MPS_ON;
          endcase
        end
      end
      default: pwr_nxt = MPS_OFF;
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      pwr_r    <= MPS_OFF;
      power_on <= 1'b0;
      asleep   <= 1'b0;
    end else begin
      pwr_r    <= pwr_nxt;
      power_on <= pwr_nxt != MPS_OFF;
      asleep   <= pwr_nxt == MPS_SLP;
    end
  end

  // ---------------------------------------------------------------
  // command answers and function level
  // ---------------------------------------------------------------
  // asleep or off nothing is answered; the waking attention is lost
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      cmd_ack <= 1'b0;
      cmd_nak <= 1'b0;
    end else begin
      cmd_ack <= 1'b0;
      cmd_nak <= 1'b0;
      if (cmd_valid && pwr_r == MPS_ON) begin
        if ((fun_r == FUN_MIN && (cmd_radio || cmd_sim)) ||
            (fun_r == FUN_NORF && cmd_radio)) begin
          cmd_nak <= 1'b1;
        end else begin
          cmd_ack <= 1'b1;
        end
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      radio_en <= 1'b0;
      sim_en   <= 1'b0;
    end else begin
      radio_en <= pwr_r != MPS_OFF && fun_r == FUN_FULL;
      sim_en   <= pwr_r != MPS_OFF && fun_r != FUN_MIN;
    end
  end

  // ---------------------------------------------------------------
  // ring line and state outputs
  // ---------------------------------------------------------------
  logic [15:0] ri_cnt_r;

  // events keep arriving while asleep, so the host is always woken
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      ri_cnt_r <= 16'h0000;
    end else if (pwr_r == MPS_OFF) begin
      ri_cnt_r <= 16'h0000;
    end else if (sms_evt || data_evt || report_evt) begin
      ri_cnt_r <= RI_PULSE_MS;
    end else if (tick_r && ri_cnt_r != 16'h0000) begin
      ri_cnt_r <= ri_cnt_r - 16'h1;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      ring_indicator <= 1'b1;
      op_state       <= 1'b0;
    end else begin
      ring_indicator <= !(pwr_r != MPS_OFF &&
                          (ri_cnt_r != 16'h0000 || call_ringing));
      op_state <= pwr_r != MPS_OFF && lte_registered;
    end
  end

  // ---------------------------------------------------------------
  // network blink
  // ---------------------------------------------------------------
  logic [15:0] bl_cnt_r;
  logic        bl_on_r;
  logic [15:0] on_ms, off_ms;
  logic        bl_act, data_up;

  assign data_up = ppp_ok | (pdp_ok & rndis_ok);

  always_comb begin
    bl_act = 1'b1;
    on_ms  = SRCH_ON_MS;
    off_ms = SRCH_OFF_MS;
    if (pwr_r == MPS_OFF) begin
      bl_act = 1'b0;
    end else if (lte_registered && data_up) begin
      on_ms  = DATA_ON_MS;
      off_ms = DATA_OFF_MS;
    end else if (lte_registered) begin
      on_ms  = IDLE_ON_MS;
      off_ms = IDLE_OFF_MS;
    end else if (!net_searching) begin
      bl_act = 1'b0;
    end
  end

  // a pattern change takes effect at the end of the running phase
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      bl_cnt_r            <= 16'h0000;
      bl_on_r             <= 1'b0;
      network_state_blink <= 1'b0;
    end else begin
      if (!bl_act) begin
        bl_cnt_r <= 16'h0000;
        bl_on_r  <= 1'b0;
      end else if (tick_r) begin
        if (bl_cnt_r == 16'h0000) begin
          bl_on_r  <= ~bl_on_r;
          bl_cnt_r <= (bl_on_r ? off_ms : on_ms) - 16'h1;
        end else begin
          bl_cnt_r <= bl_cnt_r - 16'h1;
        end
      end
      network_state_blink <= bl_act & bl_on_r;
    end
  end

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!reset_n);

  sequence s_awake_quiet;
    pwr_r == MPS_ON && !pkey_edge && !batt_s && !script_r && !sleep_req_r;
  endsequence
  sequence s_slp_quiet;
    pwr_r == MPS_SLP && !pkey_edge && !batt_s && !script_r;
  endsequence

  AST_PIN_SLEEP: assert property (
    s_awake_quiet and (sel_r == SEL_PIN && dtr_hi) |=> pwr_r == MPS_SLP)
    else $error("pin sleep not entered");
  AST_PIN_WAKE: assert property (
    s_slp_quiet and (sel_r == SEL_PIN && dtr_cnt_r == DTR_WAKE_MS + 16'h1)
    |=> pwr_r == MPS_ON)
    else $error("pin sleep not left");
  AST_PIN_HOLD: assert property (
    s_slp_quiet and (sel_r == SEL_PIN && dtr_cnt_r <= DTR_WAKE_MS)
    |=> pwr_r != MPS_ON)
    else $error("woke before low time elapsed");
  AST_DTR_RESTART: assert property (
    dtr_hi |=> dtr_cnt_r == 16'h0000)
    else $error("low time not restarted");
  AST_IDLE_RESTART: assert property (
    serial_rx_act || serial_tx_act |=> idle_cnt_r == 16'h0000)
    else $error("idle timer not restarted");
  AST_IDLE_SLEEP: assert property (
    s_awake_quiet and (sel_r == SEL_IDLE && idle_due) |=> asleep)
    else $error("idle sleep not entered");
  AST_ATTN_WAKE: assert property (
    s_slp_quiet and (sel_r == SEL_IDLE && cmd_valid && cmd_attn)
    |=> pwr_r == MPS_ON ##1 !asleep)
    else $error("attention did not wake");
  AST_NO_ANSWER: assert property (
    cmd_valid && pwr_r != MPS_ON |=> !cmd_ack && !cmd_nak)
    else $error("answered while asleep");
  AST_RI_PULSE: assert property (
    sms_evt && pwr_r != MPS_OFF |=> ri_cnt_r == RI_PULSE_MS ##1 !ring_indicator)
    else $error("ring pulse missing");
  AST_USB_RESUME: assert property (
    s_slp_quiet and (sel_r == SEL_USB && !susp_s) |=> pwr_r == MPS_ON)
    else $error("usb resume did not wake");
  AST_OP_STATE: assert property (
    !lte_registered |=> !op_state)
    else $error("operating output high unregistered");
  AST_FUN_REJECT: assert property (
    cmd_valid && cmd_radio && pwr_r == MPS_ON && fun_r != FUN_FULL
    |=> cmd_nak && !cmd_ack)
    else $error("radio command not rejected");
  AST_SIM_REJECT: assert property (
    cmd_valid && cmd_sim && pwr_r == MPS_ON && fun_r == FUN_MIN |=> cmd_nak)
    else $error("sim command not rejected");
  AST_SHUTDOWN: assert property (
    batt_s && pwr_r != MPS_OFF |=> pwr_r == MPS_OFF ##1 !power_on)
    else $error("battery shutdown missed");
  AST_BOOT_KEY: assert property (
    pwr_r == MPS_OFF && !pkey_edge |=> pwr_r == MPS_OFF)
    else $error("booted without power key");

endmodule : mps_power_ctrl
`default_nettype wire

// file: logic/mps_pkg.sv
package mps_pkg;
  // ---------------------------------------------------------------
  // clock and time base
  // ---------------------------------------------------------------
  localparam int CLK_HZ   = 125_000_000;
  localparam int TICK_MS  = 1;                       // time base step, ms
  localparam int TICK_CYC = CLK_HZ / 1000 * TICK_MS; // cycles per step

  // times in ms, counted in time base steps
  localparam logic [15:0] DTR_WAKE_MS   = 16'h0032; // 50 ms
  localparam logic [15:0] IDLE_MS_RST   = 16'h1388; // 5 s
  localparam logic [15:0] RI_PULSE_MS   = 16'h0078; // 120 ms
  localparam logic [15:0] SRCH_ON_MS    = 16'h00C8; // 0.2 s
  localparam logic [15:0] SRCH_OFF_MS   = 16'h0320; // 0.8 s
  localparam logic [15:0] IDLE_ON_MS    = 16'h0708; // 1.8 s
  localparam logic [15:0] IDLE_OFF_MS   = 16'h00C8; // 0.2 s
  localparam logic [15:0] DATA_ON_MS    = 16'h007D; // 0.125 s
  localparam logic [15:0] DATA_OFF_MS   = 16'h007D; // 0.125 s

  // ---------------------------------------------------------------
  // register map
  // ---------------------------------------------------------------
  localparam logic [3:0] REG_CTRL   = 4'h0;
  localparam logic [3:0] REG_IDLE   = 4'h1;
  localparam logic [3:0] REG_STATUS = 4'h2;

  // control fields
  localparam int CTRL_FUN_LSB   = 0;  // [2:0] function level
  localparam int CTRL_SEL_LSB   = 3;  // [4:3] sleep select
  localparam int CTRL_SCRIPT    = 5;  // scripting build
  localparam int CTRL_SLEEP_REQ = 6;  // write 1: software sleep

  localparam logic [2:0] FUN_MIN   = 3'h0;
  localparam logic [2:0] FUN_FULL  = 3'h1;
  localparam logic [2:0] FUN_NORF  = 3'h4;
  localparam logic [2:0] FUN_RST   = FUN_FULL;

  localparam logic [1:0] SEL_NONE  = 2'h0;
  localparam logic [1:0] SEL_PIN   = 2'h1;
  localparam logic [1:0] SEL_IDLE  = 2'h2;
  localparam logic [1:0] SEL_USB   = 2'h3;
  localparam logic [1:0] SEL_RST   = SEL_NONE;

  // synchronised pin slots
  localparam int PIN_DTR  = 0;
  localparam int PIN_PKEY = 1;
  localparam int PIN_BATT = 2;
  localparam int PIN_SUSP = 3;
  localparam int PIN_NUM  = 4;

  // power state
  typedef enum logic [2:0] {
    MPS_OFF = 3'b001,
    MPS_ON  = 3'b010,
    MPS_SLP = 3'b100
  } mps_pwr_t;
endpackage : mps_pkg

// file: testbench/mps_host_model.sv
`timescale 1ns/1ps
`default_nettype none
// ------------------------------------------------------------------
// host processor on the control pins and the serial command path
// ------------------------------------------------------------------
module mps_host_model (
  // clock and reset
  input  wire logic        clk_sys,
  input  wire logic        reset_n,
  // requests from the bench
  input  wire logic        host_wake,
  input  wire logic        host_susp,
  input  wire logic        attn_go,
  // device side
  input  wire logic        cmd_ack,
  input  wire logic        ring_indicator,
  output logic             term_ready_n,
  output logic             usb_suspend,
  output logic             attn_valid,
  output logic      [15:0] ri_low_len
);
  logic [2:0]  gap_r;
  logic [15:0] cnt_r;

  // pin levels follow host state, held as long as the bench asks
  assign term_ready_n = !host_wake;
  assign usb_suspend  = host_susp;

  // resend attention every eighth cycle for as long as the bench holds attn_go; only the answer cycle itself is skipped
  assign attn_valid = attn_go && (gap_r == 3'h0) && !cmd_ack;

  always_ff @(posedge clk_sys) begin
    if (!reset_n || !attn_go) begin
      gap_r <= 3'h0;
    end else begin
      gap_r <= gap_r + 3'h1;
    end
  end

  // ring line low time, latched when the line returns high
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      cnt_r      <= 16'h0;
      ri_low_len <= 16'h0;
    end else if (!ring_indicator) begin
      cnt_r <= cnt_r + 16'h1;
    end else if (cnt_r != 16'h0) begin
      ri_low_len <= cnt_r;
      cnt_r      <= 16'h0;
    end
  end
endmodule : mps_host_model
`default_nettype wire

// file: testbench/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import mps_pkg::*;
  // ------------------------------------------------------------------
  // signals
  // ------------------------------------------------------------------
  logic        clk_sys, reset_n, reg_wr, reg_rd, power_key, batt_low;
  logic [3:0]  reg_addr, wake_ev;
  logic [15:0] reg_wdata, reg_rdata, ri_len, len;
  logic        host_wake, host_susp, attn_go, attn_valid, term_ready_n, usb_suspend;
  logic        rx_act, tx_act, t_valid, t_radio, t_sim, cmd_ack, cmd_nak;
  logic        call_ringing, report_evt, alarm_evt, sys_idle;
  logic        lte, srch, ppp_ok, pdp_ok, rndis_ok;
  logic        ring_indicator, op_state, blink, power_on, asleep, radio_en, sim_en;
  int          error_cnt, checks, i;
  // level table: {radio_en, sim_en, radio cmd, sim cmd}, cmd as {ack, nak}
  logic [2:0]  fl [3] = '{FUN_MIN, FUN_NORF, FUN_FULL};
  logic [5:0]  fx [3] = '{6'h05, 6'h16, 6'h3A};

  initial begin
    clk_sys = 1'b0;
    forever #4 clk_sys = ~clk_sys;
  end

  // short time base keeps the long ms counts affordable
  mps_power_ctrl #(.TICK_CYCLES(4)) dut (
    .clk_sys(clk_sys), .reset_n(reset_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .term_ready_n(term_ready_n),
    .power_key(power_key), .batt_low(batt_low), .usb_suspend(usb_suspend),
    .serial_rx_act(rx_act | attn_valid), .serial_tx_act(tx_act), .cmd_valid(t_valid | attn_valid),
    .cmd_attn(attn_valid), .cmd_radio(t_radio), .cmd_sim(t_sim), .cmd_ack(cmd_ack),
    .cmd_nak(cmd_nak), .sms_evt(wake_ev[2]), .data_evt(wake_ev[3]),
    .call_ringing(call_ringing), .report_evt(report_evt), .gpio_evt(wake_ev[0]),
    .timer_evt(wake_ev[1]), .alarm_evt(alarm_evt), .sys_idle(sys_idle),
    .lte_registered(lte), .net_searching(srch), .ppp_ok(ppp_ok), .pdp_ok(pdp_ok),
    .rndis_ok(rndis_ok), .ring_indicator(ring_indicator), .op_state(op_state),
    .network_state_blink(blink), .power_on(power_on), .asleep(asleep),
    .radio_en(radio_en), .sim_en(sim_en));

  mps_host_model host (
    .clk_sys(clk_sys), .reset_n(reset_n), .host_wake(host_wake), .host_susp(host_susp),
    .attn_go(attn_go), .cmd_ack(cmd_ack), .ring_indicator(ring_indicator),
    .term_ready_n(term_ready_n), .usb_suspend(usb_suspend), .attn_valid(attn_valid),
    .ri_low_len(ri_len));

  // ------------------------------------------------------------------
  // access and compare tasks
  // ------------------------------------------------------------------
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic chk_rng(input string what, input int lo, input int hi,
                         input logic [15:0] got);
    checks++;
    if ((got >= lo && got <= hi) !== 1'b1) begin
      error_cnt++;
      $display("[FAIL] %s expected %0d to %0d seen %0d", what, lo, hi, got);
    end
  endtask : chk_rng

  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk_sys);
    {reg_wr, reg_addr, reg_wdata} <= {1'b1, a, d};
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask : wr

  task automatic rd(input logic [3:0] a, input logic [15:0] exp);
    @(posedge clk_sys);
    {reg_rd, reg_addr} <= {1'b1, a};
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1 chk("reg_rdata", exp, reg_rdata);
  endtask : rd

  // answer is a one-cycle pulse, so look right after the taking edge
  task automatic cmd(input logic radio, input logic sim, input logic [1:0] exp);
    @(posedge clk_sys);
    {t_valid, t_radio, t_sim} <= {1'b1, radio, sim};
    @(posedge clk_sys);
    t_valid <= 1'b0;
    #1 chk("cmd_ack_nak", {14'h0, exp}, {14'h0, cmd_ack, cmd_nak});
  endtask : cmd

  task automatic wait_lvl(input string what, ref logic s, input logic v, input int n);
    for (int k = 0; k < n; k++) begin
      if (s === v) break;
      @(posedge clk_sys);
      #1;
    end
    chk(what, {15'h0, v}, {15'h0, s});
    if (s !== v) summarize();
  endtask : wait_lvl

  task automatic len_of(ref logic s, input logic v, output logic [15:0] n);
    n = 16'h0;
    while (s === v && n < 16'h2000) begin
      @(posedge clk_sys);
      #1;
      n++;
    end
  endtask : len_of

  task automatic key();
    @(posedge clk_sys) power_key <= 1'b1;
    repeat (4) @(posedge clk_sys);
    power_key <= 1'b0;
  endtask : key

  task automatic summarize();
    if (error_cnt == 0 && checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : summarize

  // ------------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------------
  initial begin
    error_cnt = 0; checks = 0; reset_n = 1'b0; reg_wr = 1'b0; reg_rd = 1'b0;
    reg_addr = 4'h0; reg_wdata = 16'h0; power_key = 1'b0; batt_low = 1'b0;
    host_wake = 1'b1; host_susp = 1'b0; attn_go = 1'b0; rx_act = 1'b0; tx_act = 1'b0;
    t_valid = 1'b0; t_radio = 1'b0; t_sim = 1'b0; call_ringing = 1'b0; report_evt = 1'b0;
    alarm_evt = 1'b0; sys_idle = 1'b0; wake_ev = 4'h0; lte = 1'b0; srch = 1'b0;
    ppp_ok = 1'b0; pdp_ok = 1'b0; rndis_ok = 1'b0;
    // two reset edges; the pin synchronisers preset inside reset
    repeat (2) @(posedge clk_sys);
    reset_n <= 1'b1;
    rd(REG_CTRL, 16'h0001);
    rd(REG_IDLE, 16'h1388);
    rd(REG_STATUS, 16'h0009);
    rd(4'hF, 16'h0000);
    cmd(1'b0, 1'b0, 2'b00);
    key();
    wait_lvl("power_on", power_on, 1'b1, 10);
    rd(REG_STATUS, 16'h000A);
    // function levels, then an illegal level that must be ignored
    for (i = 0; i < 3; i++) begin
      wr(REG_CTRL, {13'h0, fl[i]});
      repeat (2) @(posedge clk_sys);
      #1 chk("radio_sim_en", {14'h0, fx[i][5:4]}, {14'h0, radio_en, sim_en});
      cmd(1'b1, 1'b0, fx[i][3:2]);
      cmd(1'b0, 1'b1, fx[i][1:0]);
    end
    wr(REG_CTRL, 16'h0002);
    rd(REG_CTRL, 16'h0001);
    @(posedge clk_sys) lte <= 1'b1;
    repeat (3) @(posedge clk_sys);
    #1 chk("op_state", 16'h1, {15'h0, op_state});
    @(posedge clk_sys) lte <= 1'b0;
    repeat (3) @(posedge clk_sys);
    #1 chk("op_state", 16'h0, {15'h0, op_state});
    // pin sleep, ring pulse while asleep, wake with a broken low first
    wr(REG_CTRL, 16'h0009);
    @(posedge clk_sys) host_wake <= 1'b0;
    wait_lvl("asleep", asleep, 1'b1, 10);
    rd(REG_STATUS, 16'h0004);
    cmd(1'b0, 1'b0, 2'b00);
    @(posedge clk_sys) wake_ev <= 4'h4;
    @(posedge clk_sys) wake_ev <= 4'h0;
    wait_lvl("ring_indicator", ring_indicator, 1'b0, 4);
    wait_lvl("ring_indicator", ring_indicator, 1'b1, 600);
    repeat (2) @(posedge clk_sys);
    #1 chk_rng("ring_low_cycles", 474, 488, ri_len);
    chk("asleep", 16'h1, {15'h0, asleep});
    @(posedge clk_sys) host_wake <= 1'b1;
    repeat (120) @(posedge clk_sys);
    host_wake <= 1'b0;
    repeat (8) @(posedge clk_sys);
    host_wake <= 1'b1;
    repeat (190) @(posedge clk_sys);
    #1 chk("asleep", 16'h1, {15'h0, asleep});
    wait_lvl("asleep", asleep, 1'b0, 40);
    cmd(1'b0, 1'b0, 2'b10);
    // idle sleep held off by serial traffic, left by attention
    @(posedge clk_sys) rx_act <= 1'b1;
    wr(REG_IDLE, 16'h000A);
    wr(REG_CTRL, 16'h0011);
    for (i = 0; i < 6; i++) begin
      repeat (30) @(posedge clk_sys);
      {rx_act, tx_act} <= {i[0], !i[0]};
      @(posedge clk_sys) {rx_act, tx_act} <= 2'b00;
    end
    #1 chk("asleep", 16'h0, {15'h0, asleep});
    wait_lvl("asleep", asleep, 1'b1, 70);
    @(posedge clk_sys) attn_go <= 1'b1;
    wait_lvl("asleep", asleep, 1'b0, 20);
    wait_lvl("cmd_ack", cmd_ack, 1'b1, 20);
    @(posedge clk_sys) attn_go <= 1'b0;
    // usb suspend and resume
    wr(REG_CTRL, 16'h0019);
    @(posedge clk_sys) host_susp <= 1'b1;
    wait_lvl("asleep", asleep, 1'b1, 10);
    @(posedge clk_sys) host_susp <= 1'b0;
    wait_lvl("asleep", asleep, 1'b0, 10);
    // software sleep left by each wake cause
    for (i = 0; i < 4; i++) begin
      wr(REG_CTRL, 16'h0041);
      wait_lvl("asleep", asleep, 1'b1, 6);
      @(posedge clk_sys) wake_ev <= 4'h1 << i;
      @(posedge clk_sys) wake_ev <= 4'h0;
      wait_lvl("asleep", asleep, 1'b0, 6);
    end
    rd(REG_CTRL, 16'h0001);
    wr(REG_CTRL, 16'h0021);
    @(posedge clk_sys) sys_idle <= 1'b1;
    wait_lvl("asleep", asleep, 1'b1, 6);
    @(posedge clk_sys) {sys_idle, alarm_evt} <= 2'b01;
    @(posedge clk_sys) alarm_evt <= 1'b0;
    wait_lvl("asleep", asleep, 1'b0, 6);
    wr(REG_CTRL, 16'h0001);
    // blink: context without networking stays idle pattern
    @(posedge clk_sys) {lte, pdp_ok} <= 2'b11;
    wait_lvl("blink", blink, 1'b1, 8000);
    wait_lvl("blink", blink, 1'b0, 8000);
    len_of(blink, 1'b0, len);
    chk_rng("blink_off_cycles", 796, 808, len);
    @(posedge clk_sys) rndis_ok <= 1'b1;
    wait_lvl("blink", blink, 1'b0, 8000);
    wait_lvl("blink", blink, 1'b1, 1000);
    len_of(blink, 1'b1, len);
    chk_rng("blink_on_cycles", 496, 508, len);
    @(posedge clk_sys) call_ringing <= 1'b1;
    wait_lvl("ring_indicator", ring_indicator, 1'b0, 4);
    @(posedge clk_sys) call_ringing <= 1'b0;
    // low battery shuts down, key boots and shuts down
    @(posedge clk_sys) batt_low <= 1'b1;
    wait_lvl("power_on", power_on, 1'b0, 10);
    repeat (2) @(posedge clk_sys);
    #1 chk("op_state", 16'h0, {15'h0, op_state});
    cmd(1'b0, 1'b0, 2'b00);
    @(posedge clk_sys) batt_low <= 1'b0;
    key();
    wait_lvl("power_on", power_on, 1'b1, 10);
    key();
    wait_lvl("power_on", power_on, 1'b0, 10);
    summarize();
  end
endmodule : testbench
`default_nettype wire
